//--- cldet_top.sv
// Cold-load detector top with Avalon-MM settings and status registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Three phase fundamental magnitudes are inputs refreshed every 5 ms.
// - Each phase is compared to every threshold on each evaluation.
// - Exceeded conditions clear at 97 percent of the setting.
// - One threshold value serves all three phases.
// - Low condition needs all phases below low threshold, default 0.20 nominal.
// - Inrush needs all phases above high threshold, default 1.20 nominal.
// - Any phase above overcurrent threshold drops active output at once.
// - Settings may change while running and apply without restart.
// - Condition code: normal, low, overcurrent, active, blocked.
// - Block input sampled once at start of each processing cycle.
// - Block comes from a dedicated input port.
// - Pick-up while unblocked asserts active and starts timing.
// - Pick-up while blocked asserts blocked output, nothing more.
// - Block after activation clears active at once, without waiting for the minimum duration.
// - Active only after low persists for start delay, default 10 s.
// - Inrush is timed against maximum duration, default 30 s.
// - Active held at least minimum duration unless overcurrent, block or maximum duration ends it.
// - Resettable counters count active and blocked assertions.
module cldet_top #(
  parameter int TICK_CYCLES = cldet_pkg::TICK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] phase_a_fundamental_i,
  input  wire logic [15:0] phase_b_fundamental_i,
  input  wire logic [15:0] phase_c_fundamental_i,
  input  wire logic        block_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             load_surge_active_o,
  output logic             blocked_o,
  output logic [2:0]       condition_code_o
);
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  typedef enum logic [1:0] {
    CLD_IDLE   = 2'b00,
    CLD_ACTIVE = 2'b01,
    CLD_BLOCK  = 2'b10
  } cldet_state_t;

  cldet_state_t state_r;
  logic [15:0]  ilow_r;
  logic [15:0]  ihigh_r;
  logic [15:0]  iover_r;
  logic [19:0]  tset_r;
  logic [19:0]  tmax_r;
  logic [19:0]  tmin_r;
  logic [31:0]  div_r;
  logic         tick_r;
  logic         blk_r;
  logic         inrush_seen_r;
  logic [31:0]  cnt_act_r;
  logic [31:0]  cnt_blk_r;
  logic         ack_r;
  logic         set_done;
  logic         max_done;
  logic         min_done;
  logic         low_run;
  logic         act_run;
  logic         high_run;

  cldet_cmp_if cif ();

  // ==========================================================================
  // Processing tick
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_r  <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (div_r == 32'(TICK_CYCLES - 1)) begin
      div_r  <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // Block sampled at the tick so a whole cycle sees one value.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      blk_r <= 1'b0;
    end else if (tick_r) begin
      blk_r <= block_i;
    end
  end

  assign cif.mag[0]   = phase_a_fundamental_i;
  assign cif.mag[1]   = phase_b_fundamental_i;
  assign cif.mag[2]   = phase_c_fundamental_i;
  assign cif.thr_low  = ilow_r;
  assign cif.thr_high = ihigh_r;
  assign cif.thr_over = iover_r;
  assign cif.tick     = tick_r;

  cldet_compare u_cmp (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .cmp     (cif.cmp)
  );

  // ==========================================================================
  // Timers
  // ==========================================================================
  assign low_run  = (state_r == CLD_IDLE) && cif.all_low;
  assign act_run  = (state_r == CLD_ACTIVE);
  assign high_run = act_run && cif.all_high;

  cldet_timer u_tset (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .tick_i   (tick_r),
    .run_i    (low_run),
    .set_ms_i (tset_r),
    .done_o   (set_done)
  );
  cldet_timer u_tmax (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .tick_i   (tick_r),
    .run_i    (high_run),
    .set_ms_i (tmax_r),
    .done_o   (max_done)
  );
  cldet_timer u_tmin (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .tick_i   (tick_r),
    .run_i    (act_run),
    .set_ms_i (tmin_r),
    .done_o   (min_done)
  );

  // ==========================================================================
  // Pick-up state machine
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r       <= CLD_IDLE;
      inrush_seen_r <= 1'b0;
    end else begin
      case (state_r)
        CLD_IDLE: begin
          inrush_seen_r <= 1'b0;
          if (set_done) begin
            state_r <= blk_r ? CLD_BLOCK : CLD_ACTIVE;
          end
        end
        CLD_ACTIVE: begin
          if (cif.all_high) begin
            inrush_seen_r <= 1'b1;
          end
          if (cif.any_over || blk_r || max_done) begin
            state_r <= CLD_IDLE;
          end else if (min_done && !cif.all_high) begin
            state_r <= CLD_IDLE;
          end
        end
        CLD_BLOCK: begin
          if (!cif.all_low) begin
            state_r <= CLD_IDLE;
          end
        end
        default: state_r <= CLD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      load_surge_active_o <= 1'b0;
      blocked_o           <= 1'b0;
      condition_code_o    <= cldet_pkg::COND_NORMAL;
    end else begin
      load_surge_active_o <= (state_r == CLD_ACTIVE);
      blocked_o           <= (state_r == CLD_BLOCK);
      if (state_r == CLD_BLOCK) begin
        condition_code_o <= cldet_pkg::COND_BLOCKED;
      end else if (state_r == CLD_ACTIVE) begin
        condition_code_o <= cldet_pkg::COND_ACTIVE;
      end else if (cif.any_over) begin
        condition_code_o <= cldet_pkg::COND_OVER;
      end else if (cif.all_low) begin
        condition_code_o <= cldet_pkg::COND_LOW;
      end else begin
        condition_code_o <= cldet_pkg::COND_NORMAL;
      end
    end
  end

  // ==========================================================================
  // Counters and register bus
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (reset_i || (ack_r && avs_write_i && avs_address_i == cldet_pkg::ADDR_CNTCLR)) begin
      cnt_act_r <= 32'h00000000;
      cnt_blk_r <= 32'h00000000;
    end else begin
      if (state_r == CLD_IDLE && set_done && !blk_r) begin
        cnt_act_r <= cnt_act_r + 32'h00000001;
      end
      if (state_r == CLD_IDLE && set_done && blk_r) begin
        cnt_blk_r <= cnt_blk_r + 32'h00000001;
      end
    end
  end

  // One wait cycle: request taken on the edge where waitrequest is low.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_r             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_r             <= (avs_read_i || avs_write_i) && !ack_r;
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ilow_r  <= cldet_pkg::ILOW_RST;
      ihigh_r <= cldet_pkg::IHIGH_RST;
      iover_r <= cldet_pkg::IOVER_RST;
      tset_r  <= cldet_pkg::TSET_RST;
      tmax_r  <= cldet_pkg::TMAX_RST;
      tmin_r  <= cldet_pkg::TMIN_RST;
    end else if (ack_r && avs_write_i) begin
      case (avs_address_i)
        cldet_pkg::ADDR_ILOW:  ilow_r  <= avs_writedata_i[15:0];
        cldet_pkg::ADDR_IHIGH: ihigh_r <= avs_writedata_i[15:0];
        cldet_pkg::ADDR_IOVER: iover_r <= avs_writedata_i[15:0];
        cldet_pkg::ADDR_TSET:  tset_r  <= avs_writedata_i[19:0];
        cldet_pkg::ADDR_TMAX:  tmax_r  <= avs_writedata_i[19:0];
        cldet_pkg::ADDR_TMIN:  tmin_r  <= avs_writedata_i[19:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack_r) begin
      case (avs_address_i)
        cldet_pkg::ADDR_ILOW:   avs_readdata_o <= {16'h0000, ilow_r};
        cldet_pkg::ADDR_IHIGH:  avs_readdata_o <= {16'h0000, ihigh_r};
        cldet_pkg::ADDR_IOVER:  avs_readdata_o <= {16'h0000, iover_r};
        cldet_pkg::ADDR_TSET:   avs_readdata_o <= {12'h000, tset_r};
        cldet_pkg::ADDR_TMAX:   avs_readdata_o <= {12'h000, tmax_r};
        cldet_pkg::ADDR_TMIN:   avs_readdata_o <= {12'h000, tmin_r};
        cldet_pkg::ADDR_STATUS: avs_readdata_o <= {27'h0000000, blocked_o, load_surge_active_o, condition_code_o};
        cldet_pkg::ADDR_CNTACT: avs_readdata_o <= cnt_act_r;
        cldet_pkg::ADDR_CNTBLK: avs_readdata_o <= cnt_blk_r;
        default:                avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence over_seen_s;
    state_r == CLD_ACTIVE && cif.any_over;
  endsequence

  act_over_drop_a: assert property (@(posedge clk_i) disable iff (reset_i)
    over_seen_s |-> ##2 !load_surge_active_o) else $error("active held over overcurrent");
  block_drop_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == CLD_ACTIVE && blk_r) |=> state_r == CLD_IDLE) else $error("block did not clear");
  pick_blk_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == CLD_IDLE && set_done && blk_r) |-> ##2 blocked_o && !load_surge_active_o)
    else $error("blocked pick-up wrong");
  pick_act_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == CLD_IDLE && set_done && !blk_r) |-> ##2 load_surge_active_o) else $error("pick-up missed");
  act_needs_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(state_r == CLD_ACTIVE) |-> $past(low_run)) else $error("active without low");
  blk_stable_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !tick_r |=> $stable(blk_r)) else $error("block sampled off tick");
  tick_space_a: assert property (@(posedge clk_i) disable iff (reset_i)
    tick_r |=> !tick_r) else $error("tick too close");
  code_match_a: assert property (@(posedge clk_i) disable iff (reset_i)
    load_surge_active_o |-> condition_code_o == cldet_pkg::COND_ACTIVE) else $error("code mismatch");
  min_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == CLD_ACTIVE && !min_done && !cif.any_over && !blk_r && !max_done) |=> state_r == CLD_ACTIVE)
    else $error("released before minimum");
  inrush_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == CLD_ACTIVE && inrush_seen_r && min_done && !cif.all_high) |=> state_r == CLD_IDLE)
    else $error("active held after inrush");
endmodule : cldet_top
`default_nettype wire

//--- cldet_pkg.sv
// Package with constants and types for the cold-load detector.
package cldet_pkg;
  // ==========================================================================
  // Bus register map
  // ==========================================================================
  localparam logic [3:0] ADDR_ILOW   = 4'h0;
  localparam logic [3:0] ADDR_IHIGH  = 4'h1;
  localparam logic [3:0] ADDR_IOVER  = 4'h2;
  localparam logic [3:0] ADDR_TSET   = 4'h3;
  localparam logic [3:0] ADDR_TMAX   = 4'h4;
  localparam logic [3:0] ADDR_TMIN   = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_CNTACT = 4'h7;
  localparam logic [3:0] ADDR_CNTBLK = 4'h8;
  localparam logic [3:0] ADDR_CNTCLR = 4'h9;
  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int CUR_W = 16;
  localparam int TIM_W = 20;
  localparam logic [15:0] ILOW_RST  = 16'h0014;
  localparam logic [15:0] IHIGH_RST = 16'h0078;
  localparam logic [15:0] IOVER_RST = 16'h00c8;
  localparam int TSET_MS = 10000;
  localparam int TMAX_MS = 30000;
  localparam int TMIN_MS = 40;
  localparam int TICK_MS = 5;
  localparam logic [19:0] TSET_RST = 20'(TSET_MS);
  localparam logic [19:0] TMAX_RST = 20'(TMAX_MS);
  localparam logic [19:0] TMIN_RST = 20'(TMIN_MS);
  localparam int CLK_MHZ = 100;
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  localparam int RESET_PCT = 97;
  localparam int PCT_FULL = 100;
  typedef enum logic [2:0] {
    COND_NORMAL  = 3'h0,
    COND_LOW     = 3'h1,
    COND_OVER    = 3'h2,
    COND_ACTIVE  = 3'h3,
    COND_BLOCKED = 3'h4
  } cldet_cond_t;
endpackage : cldet_pkg

//--- cldet_cmp_if.sv
// Interface carrying phase magnitudes and comparator results.
`timescale 1ns/10ps
`default_nettype none
interface cldet_cmp_if;
  logic [15:0] mag [3];
  logic [15:0] thr_low;
  logic [15:0] thr_high;
  logic [15:0] thr_over;
  logic        tick;
  logic        all_low;
  logic        all_high;
  logic        any_over;
  modport ctrl (output mag, thr_low, thr_high, thr_over, tick, input all_low, all_high, any_over);
  modport cmp  (input mag, thr_low, thr_high, thr_over, tick, output all_low, all_high, any_over);
endinterface : cldet_cmp_if
`default_nettype wire

//--- cldet_compare.sv
// Three-phase threshold comparators, with hysteresis on the high and overcurrent thresholds.
`timescale 1ns/10ps
`default_nettype none
module cldet_compare (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  cldet_cmp_if.cmp    cmp
);
  logic [2:0] low_r;
  logic [2:0] high_r;
  logic [2:0] over_r;

  // Scaled compare avoids division: mag*100 vs thr*97.
  function automatic logic hyst(input logic [15:0] m, input logic [15:0] t, input logic was_over);
    logic [23:0] mm;
    logic [23:0] tt;
    mm = 24'(m) * 24'(cldet_pkg::PCT_FULL);
    tt = 24'(t) * 24'(was_over ? cldet_pkg::RESET_PCT : cldet_pkg::PCT_FULL);
    return was_over ? (mm > tt) : (m > t);
  endfunction : hyst

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_ph
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          low_r[p]  <= 1'b0;
          high_r[p] <= 1'b0;
          over_r[p] <= 1'b0;
        end else if (cmp.tick) begin
          // Low uses inverted sense: below threshold, released at or above it.
          low_r[p]  <= !(cmp.mag[p] >= cmp.thr_low);
          high_r[p] <= hyst(cmp.mag[p], cmp.thr_high, high_r[p]);
          over_r[p] <= hyst(cmp.mag[p], cmp.thr_over, over_r[p]);
        end
      end
    end
  endgenerate

  assign cmp.all_low  = &low_r;
  assign cmp.all_high = &high_r;
  assign cmp.any_over = |over_r;
endmodule : cldet_compare
`default_nettype wire

//--- cldet_timer.sv
// Tick counter comparing elapsed ticks against a millisecond setting.
`timescale 1ns/10ps
`default_nettype none
module cldet_timer (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        tick_i,
  input  wire logic        run_i,
  input  wire logic [19:0] set_ms_i,
  output logic             done_o
);
  logic [19:0] cnt_r;
  logic [19:0] lim;
  // Round up to the next 5 ms tick.
  assign lim = 20'((set_ms_i + 20'(cldet_pkg::TICK_MS - 1)) / 20'(cldet_pkg::TICK_MS));
  always_ff @(posedge clk_i) begin
    if (reset_i || !run_i) begin
      cnt_r <= 20'h00000;
    end else if (tick_i && cnt_r < lim) begin
      cnt_r <= cnt_r + 20'h00001;
    end
  end
  assign done_o = run_i && (cnt_r >= lim);
endmodule : cldet_timer
`default_nettype wire

//--- cldet_feed_model.sv
// Behavioural model of the phase measurement stage and the blocking matrix.
`timescale 1ns/10ps
`default_nettype none
module cldet_feed_model #(
  parameter int TICK_CYCLES = 20
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] want_a_i,
  input  wire logic [15:0] want_b_i,
  input  wire logic [15:0] want_c_i,
  input  wire logic        want_block_i,
  output logic [15:0]      phase_a_fundamental_o,
  output logic [15:0]      phase_b_fundamental_o,
  output logic [15:0]      phase_c_fundamental_o,
  output logic             block_o
);
  // ==========================================================================
  // Measurement refresh
  // ==========================================================================
  // Magnitudes move only on the measurement time base, never between refreshes.
  int cnt_r;
  always_ff @(posedge clk_i) begin
    if (reset_i || cnt_r == TICK_CYCLES - 1) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_a_fundamental_o <= 16'h0000;
      phase_b_fundamental_o <= 16'h0000;
      phase_c_fundamental_o <= 16'h0000;
    end else if (cnt_r == 0) begin
      phase_a_fundamental_o <= want_a_i;
      phase_b_fundamental_o <= want_b_i;
      phase_c_fundamental_o <= want_c_i;
    end
  end
  // ==========================================================================
  // Blocking matrix
  // ==========================================================================
  // The bench raises block many ticks ahead of any timer expiry, so no lead time is lost here.
  always_ff @(posedge clk_i) begin
    block_o <= reset_i ? 1'b0 : want_block_i;
  end
endmodule : cldet_feed_model
`default_nettype wire

//--- testbench.sv
// Self-checking testbench of the cold-load detector.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        reset_i = 1'b1;
  logic [15:0] want_a = 16'h0000;
  logic [15:0] want_b = 16'h0000;
  logic [15:0] want_c = 16'h0000;
  logic        want_block = 1'b0;
  logic [15:0] pa;
  logic [15:0] pb;
  logic [15:0] pc;
  logic        blk;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        load_surge_active_o;
  logic        blocked_o;
  logic [2:0]  condition_code_o;
  int          num_errors = 0;
  int          check_count = 0;
  logic [31:0] rd;
  logic [31:0] dflt [6] = '{32'h14, 32'h78, 32'hc8, 32'h2710, 32'h7530, 32'h28};
  always #5 clk = ~clk;
  cldet_feed_model #(.TICK_CYCLES(20)) cldet_feed_model_inst (.clk_i(clk), .reset_i(reset_i),
    .want_a_i(want_a), .want_b_i(want_b), .want_c_i(want_c), .want_block_i(want_block),
    .phase_a_fundamental_o(pa), .phase_b_fundamental_o(pb), .phase_c_fundamental_o(pc), .block_o(blk));
  cldet_top #(.TICK_CYCLES(20)) cldet_top_inst (.clk_i(clk), .reset_i(reset_i),
    .phase_a_fundamental_i(pa), .phase_b_fundamental_i(pb), .phase_c_fundamental_i(pc), .block_i(blk),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .load_surge_active_o(load_surge_active_o), .blocked_o(blocked_o), .condition_code_o(condition_code_o));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  // One bus cycle; the request is held until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
    int n;
    @(posedge clk);
    avs_address_i <= addr;
    avs_writedata_i <= data;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      $display("unexpected waitrequest: expected 0, seen %b", avs_waitrequest_o);
      conclude();
    end
  endtask : bus
  task automatic set_ph(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk);
    want_a <= a;
    want_b <= b;
    want_c <= c;
  endtask : set_ph
  // The output must hold off for lo cycles and reach val within hi cycles.
  task automatic wait_out(input string name, input bit sel, input logic val, input int lo, input int hi);
    int n;
    for (n = 0; n < hi; n++) begin
      @(posedge clk);
      if ((sel ? blocked_o : load_surge_active_o) === val) break;
    end
    chk({name, " not early"}, 32'(n >= lo), 32'h1);
    chk(name, 32'(val), 32'(sel ? blocked_o : load_surge_active_o));
  endtask : wait_out
  task automatic activate();
    set_ph(16'd50, 16'd50, 16'd50);
    repeat (60) @(posedge clk);
    set_ph(16'd10, 16'd10, 16'd10);
    repeat (60) @(posedge clk);
    chk("code low", 32'(cldet_pkg::COND_LOW), 32'(condition_code_o));
    wait_out("active rise", 0, 1'b1, 80, 240);
    chk("code active", 32'(cldet_pkg::COND_ACTIVE), 32'(condition_code_o));
  endtask : activate
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic s_regs();
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 4'(i), 32'h0);
      chk("setting default", dflt[i], rd);
    end
    bus(1'b0, 4'ha, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, cldet_pkg::ADDR_TSET, 32'd50);
    bus(1'b1, cldet_pkg::ADDR_TMAX, 32'd100);
    bus(1'b1, cldet_pkg::ADDR_TMIN, 32'd40);
    bus(1'b0, cldet_pkg::ADDR_TMAX, 32'h0);
    chk("tmax", 32'd100, rd);
    // Zero phase currents lie below the low threshold, so the code reads low well after the first tick.
    bus(1'b1, cldet_pkg::ADDR_STATUS, 32'hff);
    bus(1'b0, cldet_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'(cldet_pkg::COND_LOW), rd);
  endtask : s_regs
  task automatic s_partial_low();
    set_ph(16'd10, 16'd10, 16'd50);
    repeat (400) @(posedge clk);
    chk("partial low active", 32'h0, 32'(load_surge_active_o));
    chk("partial low code", 32'(cldet_pkg::COND_NORMAL), 32'(condition_code_o));
  endtask : s_partial_low
  task automatic s_min();
    activate();
    set_ph(16'd50, 16'd50, 16'd50);
    wait_out("min release", 0, 1'b0, 100, 260);
  endtask : s_min
  task automatic s_max();
    activate();
    set_ph(16'd150, 16'd150, 16'd150);
    wait_out("max release", 0, 1'b0, 300, 500);
  endtask : s_max
  task automatic s_over();
    activate();
    set_ph(16'd150, 16'd150, 16'd250);
    wait_out("over release", 0, 1'b0, 0, 60);
    chk("code over", 32'(cldet_pkg::COND_OVER), 32'(condition_code_o));
    set_ph(16'd50, 16'd50, 16'd195);
    repeat (60) @(posedge clk);
    chk("over held", 32'(cldet_pkg::COND_OVER), 32'(condition_code_o));
    set_ph(16'd50, 16'd50, 16'd190);
    repeat (60) @(posedge clk);
    chk("over cleared", 32'(cldet_pkg::COND_NORMAL), 32'(condition_code_o));
  endtask : s_over
  task automatic s_block();
    @(posedge clk);
    want_block <= 1'b1;
    set_ph(16'd50, 16'd50, 16'd50);
    repeat (60) @(posedge clk);
    set_ph(16'd10, 16'd10, 16'd10);
    wait_out("blocked rise", 1, 1'b1, 140, 300);
    chk("blocked active", 32'h0, 32'(load_surge_active_o));
    chk("code blocked", 32'(cldet_pkg::COND_BLOCKED), 32'(condition_code_o));
    set_ph(16'd50, 16'd50, 16'd50);
    wait_out("blocked fall", 1, 1'b0, 0, 100);
    @(posedge clk);
    want_block <= 1'b0;
  endtask : s_block
  task automatic s_late_block();
    activate();
    @(posedge clk);
    want_block <= 1'b1;
    wait_out("late block release", 0, 1'b0, 0, 60);
    set_ph(16'd50, 16'd50, 16'd50);
    repeat (60) @(posedge clk);
    want_block <= 1'b0;
  endtask : s_late_block
  task automatic s_count();
    bus(1'b0, cldet_pkg::ADDR_CNTACT, 32'h0);
    chk("active count", 32'd4, rd);
    bus(1'b0, cldet_pkg::ADDR_CNTBLK, 32'h0);
    chk("blocked count", 32'd1, rd);
    bus(1'b1, cldet_pkg::ADDR_CNTCLR, 32'h1);
    bus(1'b0, cldet_pkg::ADDR_CNTACT, 32'h0);
    chk("active count cleared", 32'h0, rd);
  endtask : s_count
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("unexpected run length: expected end, seen timeout");
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_i <= 1'b0;
    s_regs();
    s_partial_low();
    s_min();
    s_max();
    s_over();
    s_block();
    s_late_block();
    s_count();
    conclude();
  end
endmodule : testbench
`default_nettype wire
